// ==== design/async_serial_control_regs.sv ====
// asynchronous serial port: apb registers, transmitter and receiver
// Functional notes
// - flip inverts every transmitted level
// - wide_char_sel picks 9 or 8 bits
// - one start, one stop, 10/11 bits
// - parity bit sits in top position
// - wakeup by address mark or idle
// - idle count starts after start/stop
// - odd or even parity select
// - transmitter interrupt from empty or done
// - receiver interrupt from full or quiet
// - tx_on rise sends preamble of ones
// - clearing tx_on finishes current character
// - re-enable mid-character queues idle character
// - rx_on gates receiver, flags kept
// - standby mutes receiver, wakeup clears it
// - break_send sends breaks back to back
// - rx_ninth_bit loads with received data
// - tx_ninth_bit loads with shift register
// - error interrupt from enabled error flags
// - unit off sets empty, done; mutes tx
// - empty flag set on buffer handoff
// - address mark wakes and sets full
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "serial_map.svh"

module async_serial_control_regs
	import serial_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_pin,
	output logic             tx_pin,
	output logic             tx_irq,
	output logic             rx_irq,
	output logic             err_irq
);

	// ************************************************************
	// declarations
	// ************************************************************
	logic [7:0]  fmt_r, fmt_nxt, ctl_r, ctl_nxt, stat_r, stat_nxt;
	logic [5:0]  ecfg_r, ecfg_nxt, arm_r, arm_nxt;
	logic [7:0]  txb_r, txb_nxt, rxb_r, rxb_nxt;
	logic        tx9_r, tx9_nxt, rx9_r, rx9_nxt;
	logic [31:0] prdata_nxt, rd_word;
	logic        pslverr_nxt, unmapped, setup, acc;
	logic        tx_irq_nxt, rx_irq_nxt, err_irq_nxt;
	logic        tick, unit_on, wide, odd, ton, brk, stby;
	logic [3:0]  len;

	tx_state_t   txs_r, txs_nxt;
	logic [10:0] txsh_r, txsh_nxt, frame;
	logic [3:0]  txcnt_r, txcnt_nxt, txph_r, txph_nxt;
	logic        pre_r, pre_nxt, ton_d_r, ton_d_nxt, tx_pin_nxt;
	logic        tx_load, do_pick, tx_done_calc, par7, par8;

	rx_state_t   rxs_r, rxs_nxt;
	logic        rxs1_r, rxs2_r;
	logic [3:0]  rxph_r, rxph_nxt, rxidx_r, rxidx_nxt, ones_r, ones_nxt;
	logic [8:0]  rxbits_r, rxbits_nxt;
	logic [1:0]  smp_r, smp_nxt;
	logic        nz_r, nz_nxt, qarm_r, qarm_nxt;
	logic        rbit, rnz, top, par_bad, deliver, rx_en;
	logic        rx_wake, rxf_set, ovr_set, nz_set, frm_set, perr_set, quiet_set;

	assign unit_on = fmt_r[`FMT_UNIT];
	assign wide    = fmt_r[`FMT_WIDE];
	assign odd     = fmt_r[`FMT_ODD];
	assign ton     = ctl_r[`CTL_TXON];
	assign brk     = ctl_r[`CTL_BRK];
	assign stby    = ctl_r[`CTL_STBY];
	assign len     = wide ? `LEN_WIDE : `LEN_NARROW;
	assign setup   = psel & ~penable;
	assign acc     = psel & penable;
	assign pready  = 1'b1; // zero wait states

	baud_tick_gen u_tick (
		.mclk  (mclk),
		.rst_n (rst_n),
		.run   (unit_on),
		.tick  (tick)
	);

	// ************************************************************
	// register file and flags
	// ************************************************************
	// read data is latched in the setup cycle so prdata is a flop
	always_comb begin
		fmt_nxt     = fmt_r;
		ctl_nxt     = ctl_r;
		ecfg_nxt    = ecfg_r;
		stat_nxt    = stat_r;
		arm_nxt     = arm_r;
		txb_nxt     = txb_r;
		rxb_nxt     = rxb_r;
		tx9_nxt     = tx9_r;
		rx9_nxt     = rx9_r;
		prdata_nxt  = prdata;
		pslverr_nxt = pslverr;
		rd_word     = 32'h0000_0000;
		unmapped    = 1'b0;
		if (paddr == `OFS_FORMAT) begin
			rd_word = {24'h00_0000, fmt_r};
		end else if (paddr == `OFS_CTRL) begin
			rd_word = {24'h00_0000, ctl_r};
		end else if (paddr == `OFS_NINTH) begin
			rd_word = {24'h00_0000, rx9_r, tx9_r, ecfg_r};
		end else if (paddr == `OFS_STATUS) begin
			rd_word = {24'h00_0000, stat_r};
		end else if (paddr == `OFS_DATA) begin
			rd_word = {24'h00_0000, rxb_r};
		end else begin
			unmapped = 1'b1;
		end
		if (setup) begin
			prdata_nxt  = rd_word;
			pslverr_nxt = unmapped;
		end
		if (rx_wake) begin
			ctl_nxt[`CTL_STBY] = 1'b0;
		end
		if (acc && pwrite && !unmapped) begin
			if (paddr == `OFS_FORMAT) begin
				fmt_nxt = pwdata[7:0];
			end else if (paddr == `OFS_CTRL) begin
				ctl_nxt = pwdata[7:0];
			end else if (paddr == `OFS_NINTH) begin
				tx9_nxt  = pwdata[`NIN_TX9];
				ecfg_nxt = pwdata[5:0]; // dma bits only stored
			end else if (paddr == `OFS_DATA) begin
				txb_nxt           = pwdata[7:0];
				stat_nxt[`ST_TXE] = 1'b0;
			end
		end
		// two-step clear: status read arms, data read clears armed bits
		if (acc && !pwrite) begin
			if (paddr == `OFS_STATUS) begin
				arm_nxt = stat_r[5:0];
			end else if (paddr == `OFS_DATA) begin
				stat_nxt[5:0] = stat_r[5:0] & ~arm_r; // only software clears
				arm_nxt       = 6'h00;
			end
		end
		// hardware sets come last so they win over a clear
		if (tx_load || !unit_on) begin
			stat_nxt[`ST_TXE] = 1'b1;
		end
		stat_nxt[`ST_DONE] = tx_done_calc;
		if (rxf_set) begin
			stat_nxt[`ST_RXF] = 1'b1;
			rxb_nxt           = rxbits_r[7:0];
			rx9_nxt           = top;
		end
		if (quiet_set) stat_nxt[`ST_QUIET] = 1'b1;
		if (ovr_set) stat_nxt[`ST_OVR] = 1'b1;
		if (nz_set) stat_nxt[`ST_NZ] = 1'b1;
		if (frm_set) stat_nxt[`ST_FRM] = 1'b1;
		if (perr_set) stat_nxt[`ST_PERR] = 1'b1;
		// requests; transmitter ones die with the unit enable
		tx_irq_nxt = unit_on & ((stat_r[`ST_TXE] & ctl_r[`CTL_TXE_IE]) |
			(stat_r[`ST_DONE] & ctl_r[`CTL_DONE_IE]));
		rx_irq_nxt = ~stby & ((stat_r[`ST_RXF] & ctl_r[`CTL_RXF_IE]) |
			(stat_r[`ST_QUIET] & ctl_r[`CTL_QUIET_IE]));
		err_irq_nxt = |(stat_r[3:0] & ecfg_r[3:0]);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fmt_r   <= `RST_FORMAT;
			ctl_r   <= `RST_CTRL;
			ecfg_r  <= `RST_ECFG;
			stat_r  <= `RST_STATUS;
			arm_r   <= 6'h00;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
			tx_irq  <= 1'b0;
			rx_irq  <= 1'b0;
			err_irq <= 1'b0;
		end else begin
			fmt_r   <= fmt_nxt;
			ctl_r   <= ctl_nxt;
			ecfg_r  <= ecfg_nxt;
			stat_r  <= stat_nxt;
			arm_r   <= arm_nxt;
			prdata  <= prdata_nxt;
			pslverr <= pslverr_nxt;
			tx_irq  <= tx_irq_nxt;
			rx_irq  <= rx_irq_nxt;
			err_irq <= err_irq_nxt;
		end
	end

	// data buffers and ninth bits keep their value through reset
	always_ff @(posedge mclk) begin
		txb_r <= txb_nxt;
		rxb_r <= rxb_nxt;
		tx9_r <= tx9_nxt;
		rx9_r <= rx9_nxt;
	end

	// ************************************************************
	// transmitter
	// ************************************************************
	assign par7  = (^txb_r[6:0]) ^ odd;
	assign par8  = (^txb_r) ^ odd;
	// frame is lsb first: start, data, top bit, stop
	assign frame = wide ?
		{1'b1, (fmt_r[`FMT_PAR] ? par8 : tx9_r), txb_r, 1'b0} :
		{2'b11, (fmt_r[`FMT_PAR] ? par7 : txb_r[7]), txb_r[6:0], 1'b0};
	assign tx_done_calc = !unit_on | ((txs_r == TX_IDLE) & stat_r[`ST_TXE] &
		!pre_r & !(brk & ton));

	always_comb begin
		txs_nxt   = txs_r;
		txsh_nxt  = txsh_r;
		txcnt_nxt = txcnt_r;
		txph_nxt  = txph_r;
		pre_nxt   = pre_r;
		ton_d_nxt = ton;
		tx_load   = 1'b0;
		do_pick   = 1'b0;
		if (ton && !ton_d_r) begin
			pre_nxt = 1'b1;
		end
		case (txs_r)
			TX_IDLE: begin
				do_pick = tick;
			end
			TX_SEND: begin
				if (tick) begin
					txph_nxt = txph_r + 4'd1;
					if (txph_r == `PH_LAST) begin
						if (txcnt_r == 4'd1) begin
							txs_nxt = TX_IDLE;
							do_pick = 1'b1; // next char starts with no gap
						end else begin
							txcnt_nxt = txcnt_r - 4'd1;
							txsh_nxt  = {1'b1, txsh_r[10:1]};
						end
					end
				end
			end
			default: begin
				txs_nxt = TX_IDLE;
			end
		endcase
		// nothing new starts once tx_on drops; the current char ends
		if (do_pick && ton) begin
			txph_nxt  = 4'd0;
			txcnt_nxt = len;
			if (brk) begin
				txsh_nxt = 11'h000; // break replaces preamble
				pre_nxt  = 1'b0;
				txs_nxt  = TX_SEND;
			end else if (pre_r) begin
				txsh_nxt = 11'h7ff;
				pre_nxt  = 1'b0;
				txs_nxt  = TX_SEND;
			end else if (!stat_r[`ST_TXE]) begin
				txsh_nxt = frame;
				tx_load  = 1'b1;
				txs_nxt  = TX_SEND;
			end
		end
		if (!unit_on) begin
			txs_nxt = TX_IDLE;
			pre_nxt = 1'b0;
		end
		tx_pin_nxt = ((txs_r == TX_SEND) ? txsh_r[0] : 1'b1) ^ fmt_r[`FMT_FLIP];
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txs_r   <= TX_IDLE;
			txsh_r  <= 11'h7ff;
			txcnt_r <= 4'd0;
			txph_r  <= 4'd0;
			pre_r   <= 1'b0;
			ton_d_r <= 1'b0;
			tx_pin  <= 1'b1;
		end else begin
			txs_r   <= txs_nxt;
			txsh_r  <= txsh_nxt;
			txcnt_r <= txcnt_nxt;
			txph_r  <= txph_nxt;
			pre_r   <= pre_nxt;
			ton_d_r <= ton_d_nxt;
			tx_pin  <= tx_pin_nxt;
		end
	end

	// ************************************************************
	// receiver
	// ************************************************************
	// two-flop synchroniser; only rxs2_r is looked at
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxs1_r <= 1'b1;
			rxs2_r <= 1'b1;
		end else begin
			rxs1_r <= rx_pin;
			rxs2_r <= rxs1_r;
		end
	end

	assign rx_en   = unit_on & ctl_r[`CTL_RXON];
	assign rbit    = (smp_r[0] & smp_r[1]) | (smp_r[0] & rxs2_r) | (smp_r[1] & rxs2_r);
	assign rnz     = !((smp_r[0] == smp_r[1]) && (smp_r[1] == rxs2_r));
	assign top     = wide ? rxbits_r[8] : rxbits_r[7];
	assign par_bad = fmt_r[`FMT_PAR] &
		(((wide ? ^rxbits_r[8:0] : ^rxbits_r[7:0])) != odd);

	always_comb begin
		rxs_nxt    = rxs_r;
		rxph_nxt   = rxph_r;
		rxidx_nxt  = rxidx_r;
		rxbits_nxt = rxbits_r;
		smp_nxt    = smp_r;
		nz_nxt     = nz_r;
		ones_nxt   = ones_r;
		qarm_nxt   = qarm_r;
		deliver    = 1'b0;
		rx_wake    = 1'b0;
		rxf_set    = 1'b0;
		ovr_set    = 1'b0;
		nz_set     = 1'b0;
		frm_set    = 1'b0;
		perr_set   = 1'b0;
		quiet_set  = 1'b0;
		if (!rx_en) begin
			rxs_nxt  = RX_HUNT;
			rxph_nxt = 4'd0;
			ones_nxt = 4'd0;
		end else if (tick) begin
			rxph_nxt = rxph_r + 4'd1;
			case (rxs_r)
				RX_HUNT: begin
					if (!rxs2_r) begin
						rxs_nxt   = RX_FRAME;
						rxph_nxt  = 4'd1;
						rxidx_nxt = 4'd0;
						nz_nxt    = 1'b0;
						ones_nxt  = 4'd0;
					end else if (rxph_r == `PH_LAST && ones_r != len) begin
						ones_nxt = ones_r + 4'd1; // ones after the stop bit
					end
				end
				RX_FRAME: begin
					if (rxph_r == `PH_S0) smp_nxt[0] = rxs2_r;
					if (rxph_r == `PH_S1) smp_nxt[1] = rxs2_r;
					if (rxph_r == `PH_S2) begin
						nz_nxt    = nz_r | rnz;
						rxidx_nxt = rxidx_r + 4'd1;
						if (!idle_sel_count_ok(rbit)) ones_nxt = 4'd0;
						else if (ones_r != len) ones_nxt = ones_r + 4'd1;
						if (rxidx_r == 4'd0) begin
							if (rbit) rxs_nxt = RX_HUNT; // false start
						end else if (rxidx_r != len - 4'd1) begin
							rxbits_nxt[rxidx_r - 4'd1] = rbit;
						end else begin
							rxs_nxt  = RX_HUNT;
							rxph_nxt = 4'd0;
							frm_set  = !rbit;
							deliver  = !stby || (fmt_r[`FMT_ADDRWAKE] && top);
							rx_wake  = stby && fmt_r[`FMT_ADDRWAKE] && top;
						end
					end
				end
				default: begin
					rxs_nxt = RX_HUNT;
				end
			endcase
			// idle character seen once the count reaches a full char
			if (ones_nxt == len && ones_r != len) begin
				if (stby && !fmt_r[`FMT_ADDRWAKE]) begin
					rx_wake = 1'b1; // waking idle sets no flag
				end else if (!stby && qarm_r) begin
					quiet_set = 1'b1;
					qarm_nxt  = 1'b0;
				end
			end
		end
		// overrun keeps the old data; the new char is dropped
		if (deliver) begin
			if (stat_r[`ST_RXF]) begin
				ovr_set = 1'b1;
				frm_set = 1'b0;
			end else begin
				rxf_set  = 1'b1;
				nz_set   = nz_nxt;
				perr_set = par_bad;
				qarm_nxt = 1'b1;
			end
		end else begin
			frm_set = 1'b0;
		end
	end

	// sel low counts data ones too; sel high waits for hunt state
	function automatic logic idle_sel_count_ok(input logic b);
		idle_sel_count_ok = b & !fmt_r[`FMT_IDLESEL];
	endfunction

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxs_r    <= RX_HUNT;
			rxph_r   <= 4'd0;
			rxidx_r  <= 4'd0;
			rxbits_r <= 9'h000;
			smp_r    <= 2'b11;
			nz_r     <= 1'b0;
			ones_r   <= 4'd0;
			qarm_r   <= 1'b0;
		end else begin
			rxs_r    <= rxs_nxt;
			rxph_r   <= rxph_nxt;
			rxidx_r  <= rxidx_nxt;
			rxbits_r <= rxbits_nxt;
			smp_r    <= smp_nxt;
			nz_r     <= nz_nxt;
			ones_r   <= ones_nxt;
			qarm_r   <= qarm_nxt;
		end
	end

endmodule

// ==== design/baud_tick_gen.sv ====
// oversampling tick divider for the serial port
`timescale 1ns/1ps
`include "serial_map.svh"

module baud_tick_gen (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic run,
	output logic      tick
);

	logic [6:0] cnt_r;
	logic [6:0] cnt_nxt;
	logic       tick_nxt;

	// ************************************************************
	// divider
	// ************************************************************
	// held at zero while the unit is off so the first bit starts clean
	always_comb begin
		cnt_nxt  = cnt_r;
		tick_nxt = 1'b0;
		if (!run) begin
			cnt_nxt = 7'h00;
		end else if (cnt_r == 7'(`TICK_DIV - 1)) begin
			cnt_nxt  = 7'h00;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 7'h01;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 7'h00;
			tick  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick  <= tick_nxt;
		end
	end

endmodule

// ==== design/serial_map.svh ====
// register map, field positions, reset values and timing of the serial port
`ifndef SERIAL_MAP_SVH
`define SERIAL_MAP_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define OFS_FORMAT   12'h000
`define OFS_CTRL     12'h004
`define OFS_NINTH    12'h008
`define OFS_STATUS   12'h00c
`define OFS_DATA     12'h010

// ************************************************************
// line_format_ctrl fields
// ************************************************************
`define FMT_UNIT     6
`define FMT_FLIP     5
`define FMT_WIDE     4
`define FMT_ADDRWAKE 3
`define FMT_IDLESEL  2
`define FMT_PAR      1
`define FMT_ODD      0

// ************************************************************
// tx_rx_ctrl fields
// ************************************************************
`define CTL_TXE_IE   7
`define CTL_DONE_IE  6
`define CTL_RXF_IE   5
`define CTL_QUIET_IE 4
`define CTL_TXON     3
`define CTL_RXON     2
`define CTL_STBY     1
`define CTL_BRK      0

// ************************************************************
// ninth_bit_err_ctrl fields (bits 5..0 held in err_cfg)
// ************************************************************
`define NIN_RX9      7
`define NIN_TX9      6
`define ECF_OVR_IE   3
`define ECF_NZ_IE    2
`define ECF_FRM_IE   1
`define ECF_PAR_IE   0

// ************************************************************
// status fields
// ************************************************************
`define ST_TXE       7
`define ST_DONE      6
`define ST_RXF       5
`define ST_QUIET     4
`define ST_OVR       3
`define ST_NZ        2
`define ST_FRM       1
`define ST_PERR      0

// ************************************************************
// reset values
// ************************************************************
`define RST_FORMAT   8'h00
`define RST_CTRL     8'h00
`define RST_ECFG     6'h00
`define RST_STATUS   8'hc0

// ************************************************************
// timing
// ************************************************************
`define MCLK_HZ      125000000
`define BIT_RATE_HZ  115200
`define OVERSAMPLE   16
`define TICK_DIV     (`MCLK_HZ / (`BIT_RATE_HZ * `OVERSAMPLE))
`define LEN_NARROW   4'd10
`define LEN_WIDE     4'd11
`define PH_S0        4'd7
`define PH_S1        4'd8
`define PH_S2        4'd9
`define PH_LAST      4'd15

`endif

// ==== design/serial_pkg.sv ====
// state types of the serial port
package serial_pkg;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_HUNT  = 2'b01,
		RX_FRAME = 2'b10
	} rx_state_t;

endpackage

// ==== verif/serial_peer.sv ====
// behavioural far-side transceiver on the serial lines
`timescale 1ns/1ps
`include "serial_map.svh"

module serial_peer (
	input  wire logic mclk,
	input  wire logic tx_pin,
	output logic      rx_pin
);
	localparam int BIT = `TICK_DIV * `OVERSAMPLE;
	// line idles high so the receiver sees a clean start edge
	initial rx_pin = 1'b1;

	// ****
	// frame send and capture, lsb first
	// ****
	task automatic send(input logic [10:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			rx_pin <= bits[i];
			repeat (BIT) @(posedge mclk);
		end
		rx_pin <= 1'b1;
	endtask

	// samples mid-bit; returns after the stop bit has fully passed
	task automatic recv(input int n, output logic [10:0] bits, output int waited);
		bits = 11'h000;
		waited = 0;
		while (tx_pin !== 1'b0 && waited < 40000) begin
			@(posedge mclk);
			waited++;
		end
		repeat (BIT / 2) @(posedge mclk);
		for (int i = 0; i < n; i++) begin
			bits[i] = tx_pin;
			repeat (BIT) @(posedge mclk);
		end
	endtask
endmodule

// ==== verif/serial_regs_monitor.sv ====
// assertion checker on the serial port register block ports
`timescale 1ns/1ps
`include "serial_map.svh"

module serial_regs_monitor (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rx_pin,
	input wire logic        tx_pin,
	input wire logic        tx_irq,
	input wire logic        rx_irq,
	input wire logic        err_irq
);
	// ****
	// shadow control bytes and idle counters
	// ****
	logic [7:0]  fmt_r;
	logic [7:0]  ctl_r;
	logic [7:0]  nin_r;
	logic [15:0] quiet_r;
	logic [15:0] pre_r;
	logic        txen_q;
	logic        wr;
	logic        rdf;
	logic        txen;
	assign wr   = psel & penable & pwrite;
	assign rdf  = psel & penable & ~pwrite;
	assign txen = fmt_r[6] & ctl_r[3];
	// quiet restarts on a flip change, since tx_pin lags the register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fmt_r   <= 8'h00;
			ctl_r   <= 8'h00;
			nin_r   <= 8'h00;
			quiet_r <= 16'h0000;
			pre_r   <= 16'h0000;
			txen_q  <= 1'b0;
		end else begin
			if (wr && paddr == `OFS_FORMAT) fmt_r <= pwdata[7:0];
			if (wr && paddr == `OFS_CTRL) ctl_r <= pwdata[7:0];
			if (wr && paddr == `OFS_NINTH) nin_r <= pwdata[7:0];
			txen_q <= txen;
			if (txen || (wr && paddr == `OFS_FORMAT && pwdata[5] != fmt_r[5]))
				quiet_r <= 16'h0000;
			else if (quiet_r != 16'hffff)
				quiet_r <= quiet_r + 16'h0001;
			// a little short of ten bit times to absorb the tick phase
			if (txen && !txen_q && quiet_r >= 16'h32c8)
				pre_r <= 16'(10 * `TICK_DIV * `OVERSAMPLE - 20);
			else if (pre_r != 16'h0000)
				pre_r <= pre_r - 16'h0001;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	tx_irq_mute_a: assert property (ctl_r[7:6] == 2'b00 && $past(ctl_r[7:6]) == 2'b00 |-> !tx_irq)
		else $error("transmit request with enables clear");
	unit_off_a: assert property (!fmt_r[6] [*2] |-> !tx_irq)
		else $error("transmit request with unit off");
	rx_irq_mute_a: assert property ($stable(ctl_r[5:4]) && ctl_r[5:4] == 2'b00 |-> !rx_irq)
		else $error("receive request with enables clear");
	err_irq_mute_a: assert property ((nin_r[3:0] == 4'h0) [*2] |-> !err_irq)
		else $error("error request with enables clear");
	fmt_read_a: assert property (rdf && paddr == `OFS_FORMAT |-> prdata[6:0] == fmt_r[6:0])
		else $error("format byte reads back wrong");
	ctl_read_a: assert property (rdf && paddr == `OFS_CTRL |-> prdata[7:2] == ctl_r[7:2])
		else $error("control byte reads back wrong");
	idle_level_a: assert property (quiet_r >= 16'h32c8 |-> tx_pin == !fmt_r[5])
		else $error("idle line level wrong");
	preamble_a: assert property (pre_r != 16'h0000 && txen && !ctl_r[0] |-> tx_pin == !fmt_r[5])
		else $error("preamble broken by a zero");
endmodule

// ==== verif/tb_async_serial_control_regs.sv ====
// self-checking bench for the serial port register block
`timescale 1ns/1ps
`include "serial_map.svh"

module tb_async_serial_control_regs
	import serial_pkg::*;
;
	localparam int BIT = `TICK_DIV * `OVERSAMPLE;
	logic        mclk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_pin;
	logic        tx_pin;
	logic        tx_irq;
	logic        rx_irq;
	logic        err_irq;
	logic [31:0] rd;
	logic        er;
	logic [10:0] fr;
	int          wt;
	int          errors;
	int          tests_run;

	async_serial_control_regs DUT (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .rx_pin, .tx_pin, .tx_irq, .rx_irq, .err_irq);
	serial_peer peer (.mclk, .tx_pin, .rx_pin);

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// ****
	// apb master and comparison helpers
	// ****
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1'b1;
		// no local limit: only the watchdog may end a stalled access
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m);
		apb(1'b0, a, 8'h00);
		chk(nm, e, rd & m);
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ****
	// main sequence
	// ****
	initial begin
		errors = 0;
		tests_run = 0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		rdchk("format", `OFS_FORMAT, 32'h00, 32'hff);
		rdchk("control", `OFS_CTRL, 32'h00, 32'hff);
		rdchk("ninth", `OFS_NINTH, 32'h00, 32'h3f);
		rdchk("status", `OFS_STATUS, 32'hc0, 32'hff);
		apb(1'b0, 12'h014, 8'h00);
		chk("unmapped", 32'h1, {31'h0, er});
		apb(1'b1, `OFS_FORMAT, 8'h3f);
		rdchk("format rw", `OFS_FORMAT, 32'h3f, 32'hff);
		apb(1'b1, `OFS_NINTH, 8'h4e);
		rdchk("ninth rw", `OFS_NINTH, 32'h4e, 32'h7f);
		apb(1'b1, `OFS_NINTH, 8'h02);
		// receive: plain byte, then bad parity with a zero stop bit
		apb(1'b1, `OFS_FORMAT, 8'h40);
		apb(1'b1, `OFS_CTRL, 8'h24);
		peer.send(11'({1'b1, 8'h96, 1'b0}), 10);
		repeat (4) @(posedge mclk);
		chk("rx irq", 32'h1, {31'h0, rx_irq});
		rdchk("rx full", `OFS_STATUS, 32'h20, 32'h20);
		rdchk("rx data", `OFS_DATA, 32'h96, 32'hff);
		rdchk("rx ninth", `OFS_NINTH, 32'h80, 32'h80);
		apb(1'b1, `OFS_FORMAT, 8'h43);
		peer.send(11'({1'b0, 1'b1, 7'h31, 1'b0}), 10);
		repeat (4) @(posedge mclk);
		chk("err irq", 32'h1, {31'h0, err_irq});
		rdchk("errors", `OFS_STATUS, 32'h03, 32'h03);
		rdchk("drain", `OFS_DATA, 32'h31, 32'h7f);
		apb(1'b1, `OFS_CTRL, 8'h00);
		// standby with address-mark wakeup: a top bit of one wakes and delivers
		apb(1'b1, `OFS_FORMAT, 8'h48);
		apb(1'b1, `OFS_CTRL, 8'h26);
		peer.send(11'({1'b1, 8'h85, 1'b0}), 10);
		repeat (4) @(posedge mclk);
		rdchk("wake standby", `OFS_CTRL, 32'h24, 32'hff);
		rdchk("wake full", `OFS_STATUS, 32'h20, 32'h20);
		chk("wake irq", 32'h1, {31'h0, rx_irq});
		apb(1'b1, `OFS_CTRL, 8'h00);
		rdchk("rx off keeps", `OFS_STATUS, 32'h20, 32'h20);
		rdchk("wake data", `OFS_DATA, 32'h85, 32'hff);
		apb(1'b1, `OFS_NINTH, 8'h00);
		// transmit: preamble then even parity byte, then wide frame
		apb(1'b1, `OFS_FORMAT, 8'h42);
		apb(1'b1, `OFS_CTRL, 8'h88);
		repeat (3) @(posedge mclk);
		chk("tx irq", 32'h1, {31'h0, tx_irq});
		apb(1'b1, `OFS_DATA, 8'h31);
		peer.recv(10, fr, wt);
		chk("tx frame", 32'({1'b1, ^7'h31, 7'h31, 1'b0}), 32'(fr));
		chk("preamble", 32'h1, 32'(wt >= 10 * BIT - 8 && wt < 40000));
		apb(1'b1, `OFS_FORMAT, 8'h50);
		apb(1'b1, `OFS_NINTH, 8'h40);
		apb(1'b1, `OFS_DATA, 8'ha5);
		peer.recv(11, fr, wt);
		chk("wide frame", 32'({1'b1, 1'b1, 8'ha5, 1'b0}), 32'(fr));
		apb(1'b1, `OFS_CTRL, 8'h00);
		repeat (3) @(posedge mclk);
		chk("tx irq off", 32'h0, {31'h0, tx_irq});
		apb(1'b1, `OFS_FORMAT, 8'h60);
		repeat (4) @(posedge mclk);
		chk("flip idle", 32'h0, {31'h0, tx_pin});
		apb(1'b1, `OFS_FORMAT, 8'h40);
		repeat (4) @(posedge mclk);
		chk("plain idle", 32'h1, {31'h0, tx_pin});
		give_verdict();
	end

	// cuts a hang well past the expected run of about seventy thousand cycles
	initial begin
		repeat (95000) @(posedge mclk);
		errors++;
		give_verdict();
	end
endmodule

bind async_serial_control_regs serial_regs_monitor mon (.mclk, .rst_n, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_pin, .tx_pin, .tx_irq,
	.rx_irq, .err_irq);
